// *** core/dec_engine_ctrl.v ***
// Drawing engine command word register, decode and run control
`timescale 1ns/1ps
`default_nettype none
`include "dec_defines.vh"

// How it works
// - Writing activate one starts; resets to idle
// - Write back destination X when enabled
// - Quick start launches on X dimension write
// - Direction bit: horizontal stroke, right-to-left blit
// - Major axis bit picks Y or X
// - Step field picks rotation or axis flip
// - Stretch bit enables Y-only stretch
// - Host source bit selects mono or colour
// - Last-pixel bit draws final vector pixel
// - Capture bit enables host read capture
// - Codes 0,1,3: blit, rect, trapezoid fill
// - Codes 5,6,7: strip, stroke, line
// - Codes 8-b: host blits and rotation blit
// - Repeat rotation only with rotation blit; lengths
module dec_engine_ctrl (
  input  wire                      clk_sys,
  input  wire                      nrst,
  // Register port
  input  wire [`DEC_ADDR_W-1:0]    reg_addr,
  input  wire [15:0]               reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [15:0]               reg_rdata,
  // Datapath handshake
  input  wire                      eng_done,
  input  wire [`DEC_DIMX_W-1:0]    eng_dest_x,
  output wire                      eng_start,
  output reg                       eng_busy,
  output reg  [`DEC_NOPS-1:0]      eng_op,
  output reg                       eng_dir_rtl,
  output reg                       eng_stroke_horiz,
  output reg                       eng_major_y,
  output reg  [1:0]                eng_step,
  output reg                       eng_stretch_y,
  output reg                       eng_host_mono,
  output reg                       eng_last_pixel,
  output reg                       eng_capture,
  output reg                       eng_color_pattern,
  output reg                       eng_repeat_rot,
  output reg  [`DEC_DIMX_W-1:0]    eng_length,
  output reg  [`DEC_DIMX_W-1:0]    eng_dim_x,
  output reg  [`DEC_DIMX_W-1:0]    dest_x
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg  [15:0]               cmd_r;
  reg  [`DEC_DIMX_W-1:0]    dimx_r;
  reg  [`DEC_DIMX_W-1:0]    destx_r;
  reg                       rot_rep_r;
  reg                       state_r;
  reg                       state_nxt;
  reg                       reserved_seen_r;
  wire [`DEC_NOPS-1:0]      op_onehot;
  wire                      op_reserved;
  wire                      wr_cmd;
  wire [15:0]               cmd_nxt;
  wire                      wr_dimx;
  wire                      go_explicit;
  wire                      go_quick;
  wire                      start;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  dec_op_decode u_decode (
    .op_code     (cmd_nxt[`DEC_OP_HI:`DEC_OP_LO]),
    .op_onehot   (op_onehot),
    .op_reserved (op_reserved)
  );

  // ----------------------------------------------------------------
  // Start conditions
  // ----------------------------------------------------------------
  assign wr_cmd  = reg_wr && (reg_addr == `DEC_ADDR_CMD);
  assign wr_dimx = reg_wr && (reg_addr == `DEC_ADDR_DIMX);
  // Decode the word being written, so a launch runs its own command
  assign cmd_nxt = wr_cmd ? {1'b0, reg_wdata[`DEC_BIT_PATTERN:0]} : cmd_r;
  // Writing a one to activate launches the command
  assign go_explicit = wr_cmd && reg_wdata[`DEC_BIT_ACTIVATE];
  // X dimension write alone launches when quick start is on
  assign go_quick = wr_dimx && cmd_r[`DEC_BIT_QUICK];
  // Starts while busy are dropped: datapath cannot take two at once
  assign start     = (state_r == ST_IDLE) && (go_explicit || go_quick);
  assign eng_start = start;

  // ----------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start) begin
        state_nxt = ST_RUN;
      end
      ST_RUN: if (eng_done) begin
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cmd_r     <= `DEC_CMD_RESET;
      dimx_r    <= {`DEC_DIMX_W{1'b0}};
      rot_rep_r <= 1'b0;
    end else begin
      if (wr_cmd) begin
        // Activate is held by the engine, not stored from software
        cmd_r <= cmd_nxt;
      end
      if (wr_dimx) begin
        dimx_r <= reg_wdata[`DEC_DIMX_W-1:0];
      end
      if (reg_wr && (reg_addr == `DEC_ADDR_ROTCTL)) begin
        rot_rep_r <= reg_wdata[0];
      end
    end
  end

  // Destination X: software load, engine writeback on completion
  always @(posedge clk_sys) begin
    if (!nrst) begin
      destx_r <= {`DEC_DIMX_W{1'b0}};
    end else if ((state_r == ST_RUN) && eng_done && cmd_r[`DEC_BIT_DESTX_WB]) begin
      destx_r <= eng_dest_x;
    end else if (reg_wr && (reg_addr == `DEC_ADDR_DESTX)) begin
      destx_r <= reg_wdata[`DEC_DIMX_W-1:0];
    end
  end

  // Sticky flag for a launch with a reserved code; cleared on command write
  always @(posedge clk_sys) begin
    if (!nrst) begin
      reserved_seen_r <= 1'b0;
    end else if (start && op_reserved) begin
      reserved_seen_r <= 1'b1;
    end else if (wr_cmd) begin
      reserved_seen_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Operation controls to the datapath, registered
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      eng_busy          <= 1'b0;
      eng_op            <= {`DEC_NOPS{1'b0}};
      eng_dir_rtl       <= 1'b0;
      eng_stroke_horiz  <= 1'b0;
      eng_major_y       <= 1'b0;
      eng_step          <= `DEC_STEP_FLIP_RT;
      eng_stretch_y     <= 1'b0;
      eng_host_mono     <= 1'b0;
      eng_last_pixel    <= 1'b0;
      eng_capture       <= 1'b0;
      eng_color_pattern <= 1'b0;
      eng_repeat_rot    <= 1'b0;
      eng_length        <= {`DEC_DIMX_W{1'b0}};
      eng_dim_x         <= {`DEC_DIMX_W{1'b0}};
      dest_x            <= {`DEC_DIMX_W{1'b0}};
    end else begin
      eng_busy <= (state_nxt == ST_RUN);
      eng_op   <= op_onehot;
      // Same bit steers blit direction and stroke orientation
      eng_dir_rtl      <= cmd_nxt[`DEC_BIT_DIR] && (op_onehot[`DEC_ONE_BLIT] ||
                          op_onehot[`DEC_ONE_ROT]);
      eng_stroke_horiz <= cmd_nxt[`DEC_BIT_DIR] &&
                          op_onehot[`DEC_ONE_STROKE];
      eng_major_y      <= cmd_nxt[`DEC_BIT_MAJOR_Y];
      eng_step         <= cmd_nxt[`DEC_STEP_HI:`DEC_STEP_LO];
      eng_stretch_y    <= cmd_nxt[`DEC_BIT_STRETCH];
      // Source format only matters on host-sourced blits
      eng_host_mono    <= cmd_nxt[`DEC_BIT_MONO] && (op_onehot[`DEC_ONE_HWR] ||
                          op_onehot[`DEC_ONE_HWRLB]);
      eng_last_pixel   <= cmd_nxt[`DEC_BIT_LASTPIX] &&
                          op_onehot[`DEC_ONE_LINE];
      eng_capture      <= cmd_nxt[`DEC_BIT_CAPTURE];
      eng_color_pattern <= cmd_nxt[`DEC_BIT_PATTERN];
      eng_repeat_rot   <= rot_rep_r && op_onehot[`DEC_ONE_ROT];
      // Stroke and line read the X dimension as a length
      eng_length       <= (op_onehot[`DEC_ONE_STROKE] || op_onehot[`DEC_ONE_LINE]) ?
                          dimx_r : {`DEC_DIMX_W{1'b0}};
      eng_dim_x        <= dimx_r;
      dest_x           <= destx_r;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        // Activate shows the live run state for polling
        `DEC_ADDR_CMD:    reg_rdata <= {(state_r == ST_RUN), cmd_r[14:0]};
        `DEC_ADDR_DIMX:   reg_rdata <= {4'h0, dimx_r};
        `DEC_ADDR_DESTX:  reg_rdata <= {4'h0, destx_r};
        `DEC_ADDR_STATUS: reg_rdata <= {13'h0000, reserved_seen_r, op_reserved,
                                        (state_r == ST_RUN)};
        `DEC_ADDR_ROTCTL: reg_rdata <= {15'h0000, rot_rep_r};
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // dec_engine_ctrl
`default_nettype wire

// *** core/dec_defines.vh ***
// Constants for the drawing engine command and control block
`ifndef DEC_DEFINES_VH
`define DEC_DEFINES_VH

// ----------------------------------------------------------------
// Register map (word addresses on the plain register port)
// ----------------------------------------------------------------
`define DEC_ADDR_W          4
`define DEC_ADDR_CMD        4'h0
`define DEC_ADDR_DIMX       4'h1
`define DEC_ADDR_DESTX      4'h2
`define DEC_ADDR_STATUS     4'h3
`define DEC_ADDR_ROTCTL     4'h4

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define DEC_BIT_ACTIVATE    15
`define DEC_BIT_PATTERN     14
`define DEC_BIT_DESTX_WB    13
`define DEC_BIT_QUICK       12
`define DEC_BIT_DIR         11
`define DEC_BIT_MAJOR_Y     10
`define DEC_STEP_HI         9
`define DEC_STEP_LO         8
`define DEC_BIT_STRETCH     7
`define DEC_BIT_MONO        6
`define DEC_BIT_LASTPIX     5
`define DEC_BIT_CAPTURE     4
`define DEC_OP_HI           3
`define DEC_OP_LO           0
`define DEC_CMD_RESET       16'h0000
`define DEC_DIMX_W          12

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define DEC_OP_BLIT         4'h0
`define DEC_OP_RECT_FILL    4'h1
`define DEC_OP_TRAP_FILL    4'h3
`define DEC_OP_RLE_STRIP    4'h5
`define DEC_OP_SHORT_STROKE 4'h6
`define DEC_OP_LINE         4'h7
`define DEC_OP_HOST_WR      4'h8
`define DEC_OP_HOST_RD      4'h9
`define DEC_OP_HOST_WR_LB   4'ha
`define DEC_OP_ROT_BLIT     4'hb

// ----------------------------------------------------------------
// Rotation step codes
// ----------------------------------------------------------------
`define DEC_STEP_FLIP_RT    2'h0
`define DEC_STEP_CCW90      2'h1
`define DEC_STEP_CW90       2'h2
`define DEC_STEP_FLIP_LT    2'h3

// ----------------------------------------------------------------
// Operation one-hot vector positions
// ----------------------------------------------------------------
`define DEC_NOPS            10
`define DEC_ONE_BLIT        0
`define DEC_ONE_RECT        1
`define DEC_ONE_TRAP        2
`define DEC_ONE_RLE         3
`define DEC_ONE_STROKE      4
`define DEC_ONE_LINE        5
`define DEC_ONE_HWR         6
`define DEC_ONE_HRD         7
`define DEC_ONE_HWRLB       8
`define DEC_ONE_ROT         9

`endif

// *** core/dec_op_decode.v ***
// Command code decoder for the drawing engine
`timescale 1ns/1ps
`default_nettype none
`include "dec_defines.vh"

module dec_op_decode (
  input  wire [3:0]             op_code,
  output reg  [`DEC_NOPS-1:0]   op_onehot,
  output reg                    op_reserved
);

  // ----------------------------------------------------------------
  // Pure decode of the four-bit command field
  // ----------------------------------------------------------------
  always @* begin
    op_onehot   = {`DEC_NOPS{1'b0}};
    op_reserved = 1'b0;
    case (op_code)
      `DEC_OP_BLIT:         op_onehot[`DEC_ONE_BLIT]   = 1'b1;
      `DEC_OP_RECT_FILL:    op_onehot[`DEC_ONE_RECT]   = 1'b1;
      `DEC_OP_TRAP_FILL:    op_onehot[`DEC_ONE_TRAP]   = 1'b1;
      `DEC_OP_RLE_STRIP:    op_onehot[`DEC_ONE_RLE]    = 1'b1;
      `DEC_OP_SHORT_STROKE: op_onehot[`DEC_ONE_STROKE] = 1'b1;
      `DEC_OP_LINE:         op_onehot[`DEC_ONE_LINE]   = 1'b1;
      `DEC_OP_HOST_WR:      op_onehot[`DEC_ONE_HWR]    = 1'b1;
      `DEC_OP_HOST_RD:      op_onehot[`DEC_ONE_HRD]    = 1'b1;
      `DEC_OP_HOST_WR_LB:   op_onehot[`DEC_ONE_HWRLB]  = 1'b1;
      `DEC_OP_ROT_BLIT:     op_onehot[`DEC_ONE_ROT]    = 1'b1;
      default:              op_reserved                = 1'b1;
    endcase
  end

endmodule // dec_op_decode
`default_nettype wire

// *** verif/dec_dp_model.sv ***
// Behavioural model of the pixel datapath behind the control block
`timescale 1ns/1ps
`default_nettype none

module dec_dp_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        eng_start,
  input  wire logic [7:0]  lat,
  input  wire logic [11:0] dx,
  output var  logic        eng_done,
  output var  logic [11:0] eng_dest_x
);
  logic [7:0] cnt_r;

  // Finish a launched command after lat cycles, lat of one is prompt
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      eng_done <= 1'b0;
      eng_dest_x <= 12'h000;
    end else begin
      eng_done <= 1'b0;
      eng_dest_x <= ~eng_dest_x; // Toggles so stale data never looks valid
      if (eng_start) begin
        cnt_r <= lat;
      end else if (cnt_r == 8'h01) begin
        cnt_r <= 8'h00;
        eng_done <= 1'b1;
        eng_dest_x <= dx;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // dec_dp_model
`default_nettype wire

// *** verif/dec_engine_ctrl_chk.sv ***
// Assertion checker for the drawing engine control block
`timescale 1ns/1ps
`default_nettype none
`include "dec_defines.vh"

module dec_engine_ctrl_chk (
  input wire logic [`DEC_ADDR_W-1:0] reg_addr,
  input wire logic                   clk_sys,
  input wire logic                   nrst,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  input wire logic                   eng_done,
  input wire logic                   eng_start,
  input wire logic                   eng_busy,
  input wire logic [`DEC_NOPS-1:0]   eng_op,
  input wire logic [1:0]             eng_step,
  input wire logic                   eng_stroke_horiz,
  input wire logic                   eng_last_pixel,
  input wire logic                   eng_repeat_rot,
  input wire logic [11:0]            eng_length
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic q_r;

  // Shadow of the quick start bit, taken from each command write
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q_r <= 1'b0;
    end else if (reg_wr && reg_addr == `DEC_ADDR_CMD) begin
      q_r <= reg_wdata[12];
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_ACT_START: assert property (reg_wr && reg_addr == `DEC_ADDR_CMD
    && reg_wdata[15] && !eng_busy |-> eng_start) else $error("activate write did not start");
  AST_START_SRC: assert property (eng_start |-> reg_wr && !eng_busy)
    else $error("start without an idle write");
  AST_QUICK: assert property (reg_wr && reg_addr == `DEC_ADDR_DIMX
    && q_r && !eng_busy |-> eng_start) else $error("quick start missed");
  AST_BUSY: assert property (eng_start |=> eng_busy) else $error("busy not raised");
  AST_IDLE: assert property (eng_busy && eng_done |=> !eng_busy)
    else $error("busy not cleared");
  AST_STEP: assert property (reg_wr && reg_addr == `DEC_ADDR_CMD |=>
    eng_step == $past(reg_wdata[9:8])) else $error("step field wrong");
  AST_LINE: assert property (reg_wr && reg_addr == `DEC_ADDR_CMD
    && reg_wdata[3:0] == 4'h7 |=> eng_op[5]) else $error("line code not decoded");
  AST_ONEHOT: assert property ($onehot0(eng_op)) else $error("op not one-hot");
  AST_LEN: assert property (eng_length != 12'h000 |-> eng_op[4] || eng_op[5])
    else $error("length outside stroke or line");
  AST_ROT: assert property (eng_repeat_rot |-> eng_op[9])
    else $error("repeat off rotation");
  AST_LAST: assert property (eng_last_pixel |-> eng_op[5])
    else $error("last pixel off line");
  AST_STROKE: assert property (eng_stroke_horiz |-> eng_op[4])
    else $error("stroke dir");
  AST_RDATA: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("rdata not zero");

  CV_START: cover property (eng_start);
  CV_DONE: cover property (eng_busy && eng_done);
  CV_ROT: cover property (eng_repeat_rot);
endmodule // dec_engine_ctrl_chk

bind dec_engine_ctrl dec_engine_ctrl_chk u_chk (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .eng_done, .eng_start, .eng_busy, .eng_op, .eng_step, .eng_stroke_horiz,
  .eng_last_pixel, .eng_repeat_rot, .eng_length);
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the drawing engine control block
`timescale 1ns/1ps
`default_nettype none
`include "dec_defines.vh"

module testbench;
  logic                   clk_sys = 1'b0;
  logic                   nrst = 1'b0;
  logic [`DEC_ADDR_W-1:0] reg_addr = 4'h0;
  logic [15:0]            reg_wdata = 16'h0000;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [7:0]             lat = 8'h14;
  logic [11:0]            dx = 12'h5a5;
  logic [15:0]            n_start = 16'h0000;
  logic [15:0]            x;
  logic [9:0]             e;
  logic [1:0]             b;
  int                     n_fail = 0;
  int                     n_checks = 0;
  wire [15:0] reg_rdata;
  wire [9:0]  eng_op;
  wire [1:0]  eng_step;
  wire [11:0] eng_dest_x, eng_length, eng_dim_x, dest_x;
  wire eng_done, eng_start, eng_busy, eng_dir_rtl, eng_stroke_horiz, eng_major_y, eng_stretch_y;
  wire eng_host_mono, eng_last_pixel, eng_capture, eng_color_pattern, eng_repeat_rot;
  wire [13:0] flags = {eng_op, eng_dir_rtl, eng_stroke_horiz, eng_last_pixel, eng_host_mono};
  wire [6:0]  modes = {eng_color_pattern, eng_major_y, eng_step, eng_stretch_y, eng_capture,
                       eng_dir_rtl};

  dec_engine_ctrl dut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .eng_done, .eng_dest_x, .eng_start, .eng_busy, .eng_op, .eng_dir_rtl, .eng_stroke_horiz,
    .eng_major_y, .eng_step, .eng_stretch_y, .eng_host_mono, .eng_last_pixel, .eng_capture,
    .eng_color_pattern, .eng_repeat_rot, .eng_length, .eng_dim_x, .dest_x);
  dec_dp_model u_dp (.clk_sys, .nrst, .eng_start, .lat, .dx, .eng_done, .eng_dest_x);

  // ----------------------------------------
  // Clock, launch counter, helpers
  // ----------------------------------------
  always #2 clk_sys = ~clk_sys;

  // Start is a one-cycle pulse, so count it where it stands
  always @(posedge clk_sys) begin
    if (eng_start) n_start <= n_start + 16'h0001;
  end

  function automatic logic [9:0] op_exp(input logic [3:0] c);
    case (c)
      4'h0: op_exp = 10'h001;
      4'h1: op_exp = 10'h002;
      4'h3: op_exp = 10'h004;
      4'h5: op_exp = 10'h008;
      4'h6: op_exp = 10'h010;
      4'h7: op_exp = 10'h020;
      4'h8: op_exp = 10'h040;
      4'h9: op_exp = 10'h080;
      4'ha: op_exp = 10'h100;
      4'hb: op_exp = 10'h200;
      default: op_exp = 10'h000;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] ex);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, ex);
  endtask

  task automatic step1;
    @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait, a stuck engine shows as a failed compare
  task automatic wait_idle;
    repeat (200) if (eng_busy) @(posedge clk_sys);
    #1;
    chk({15'h0000, eng_busy}, 16'h0000);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk(`DEC_ADDR_CMD, 16'h0000);
    rdchk(4'hf, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      wr(`DEC_ADDR_CMD, 16'h0860 | 16'(c));
      step1();
      e = op_exp(4'(c));
      x = {2'b00, e, e[0] | e[9], e[4], e[5], e[6] | e[8]};
      chk({2'b00, flags}, x);
    end
    for (int s = 0; s < 4; s++) begin
      b = 2'(s);
      wr(`DEC_ADDR_CMD, {1'b0, b[0], 3'b000, b[1], b, b[0], 2'b00, b[1], 4'h0});
      step1();
      chk({9'h000, modes}, {9'h000, b[0], b[1], b, b[0], b[1], 1'b0});
    end
    // Slow engine, diagonal line with write-back of destination X
    wr(`DEC_ADDR_DIMX, 16'h0123);
    wr(`DEC_ADDR_CMD, 16'ha007);
    chk(n_start, 16'h0001);
    step1();
    chk({4'h0, eng_length}, 16'h0123);
    chk({4'h0, eng_dim_x}, 16'h0123);
    rdchk(`DEC_ADDR_CMD, 16'ha007);
    // A second activate while running must not launch again
    wr(`DEC_ADDR_CMD, 16'ha007);
    chk(n_start, 16'h0001);
    wait_idle();
    rdchk(`DEC_ADDR_DESTX, 16'h05a5);
    chk({4'h0, dest_x}, 16'h05a5);
    rdchk(`DEC_ADDR_CMD, 16'h2007);
    // Prompt engine, no write-back
    lat = 8'h01;
    wr(`DEC_ADDR_DESTX, 16'h0011);
    wr(`DEC_ADDR_CMD, 16'h8001);
    wait_idle();
    rdchk(`DEC_ADDR_DESTX, 16'h0011);
    // Quick start on the dimension write
    wr(`DEC_ADDR_CMD, 16'h1006);
    chk(n_start, 16'h0002);
    wr(`DEC_ADDR_DIMX, 16'h0040);
    chk(n_start, 16'h0003);
    step1();
    chk({4'h0, eng_length}, 16'h0040);
    wait_idle();
    // Reserved code still launches and leaves the sticky flag
    wr(`DEC_ADDR_CMD, 16'h8002);
    wait_idle();
    rdchk(`DEC_ADDR_STATUS, 16'h0006);
    wr(`DEC_ADDR_CMD, 16'h0002);
    rdchk(`DEC_ADDR_STATUS, 16'h0002);
    wr(`DEC_ADDR_ROTCTL, 16'h0001);
    wr(`DEC_ADDR_CMD, 16'h000b);
    step1();
    chk({15'h0000, eng_repeat_rot}, 16'h0001);
    wr(`DEC_ADDR_CMD, 16'h0000);
    step1();
    chk({15'h0000, eng_repeat_rot}, 16'h0000);
    report_and_stop();
  end

  // Watchdog well beyond the roughly 135 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
